/* File: rtl/scf_pkg.sv */
package scf_pkg;

	// ==========================================================
	// packet framing constants
	localparam logic [7:0]  SCF_START_BYTE   = 8'h3a;
	localparam logic [7:0]  SCF_TERM_CR      = 8'h0d;
	localparam logic [7:0]  SCF_TERM_LF      = 8'h0a;
	localparam logic [15:0] SCF_DEF_ADDR     = 16'h0001;
	localparam int          SCF_PAYLOAD_W    = 16;
	localparam logic [15:0] SCF_ZERO16       = 16'h0000;
	localparam logic [15:0] SCF_ONE16        = 16'h0001;

	// ==========================================================
	// request issued by the host user
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] cmd;
		logic [15:0] len;
	} scf_hdr_t;

	// ==========================================================
	// byte stream beat (payload bytes)
	typedef struct packed {
		logic [7:0] data;
		logic       last;
	} scf_beat_t;

	// ==========================================================
	// parsed response summary
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] cmd;
		logic [15:0] len;
		logic        sum_err;
		logic        term_err;
	} scf_resp_t;

	typedef enum logic [3:0] {
		SCF_FLD_START,
		SCF_FLD_ADDR_L,
		SCF_FLD_ADDR_H,
		SCF_FLD_CMD_L,
		SCF_FLD_CMD_H,
		SCF_FLD_LEN_L,
		SCF_FLD_LEN_H,
		SCF_FLD_DATA,
		SCF_FLD_SUM_L,
		SCF_FLD_SUM_H,
		SCF_FLD_CR,
		SCF_FLD_LF
	} scf_field_t;

endpackage : scf_pkg

/* File: rtl/scf_skid_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-entry buffer: a stall on the drain side loses no word
module scf_skid_buf #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clock,   // system clock
	input  wire logic             i_sys_rst, // sync reset
	input  wire logic [WIDTH-1:0] i_data,    // fill data
	input  wire logic             i_valid,   // fill valid
	output logic                  o_ready,   // room for a word
	output logic      [WIDTH-1:0] o_data,    // drain data
	output logic                  o_valid,   // word available
	input  wire logic             i_ready    // drain accepts
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign push    = i_valid && (count_r != (AW+1)'(DEPTH));
	assign pop     = (count_r != '0) && i_ready;
	assign o_ready = (count_r != (AW+1)'(DEPTH));
	assign o_valid = (count_r != '0);
	assign o_data  = mem_r[rd_ptr_r];

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_r[wr_ptr_r] <= i_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : scf_skid_buf
`default_nettype wire

/* File: rtl/scf_host_framer.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - host alone starts a transaction; one request outstanding until reply ends
// - every packet starts with byte 3Ah; receiver restarts on it (here 3Ah is sought only between frames; mid-frame it is a field byte)
// - sensor address at bytes 1 and 2, low byte first
// - command number at bytes 3 and 4, low byte first
// - payload length n at bytes 5 and 6, low byte first
// - exactly n payload bytes from byte 7; none when n is zero
// - checksum sums bytes 1 to last payload, sent low then high
// - receiver recomputes checksum and flags mismatch
// - packet ends with 0Dh then 0Ah
// - GET usually carries no payload; reply carries requested data
// - multi-byte payload values go least significant byte first
module scf_host_framer
	import scf_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic       i_clock,      // 40 MHz system clock
	input  wire logic       i_sys_rst,    // sync reset, active high
	input  wire scf_hdr_t   i_req_hdr,    // request header
	input  wire logic       i_req_valid,  // start a request
	output logic            o_req_ready,  // idle, request may be taken
	input  wire logic [7:0] i_pl_data,    // request payload byte
	input  wire logic       i_pl_valid,   // payload byte valid
	output logic            o_pl_ready,   // payload byte taken
	output logic [7:0]      o_tx_data,    // serial link byte out
	output logic            o_tx_valid,   // link byte valid
	input  wire logic       i_tx_ready,   // link accepts byte
	input  wire logic [7:0] i_rx_data,    // serial link byte in
	input  wire logic       i_rx_valid,   // link byte strobe
	output logic [7:0]      o_rpl_data,   // reply payload byte
	output logic            o_rpl_last,   // last reply payload byte
	output logic            o_rpl_valid,  // reply payload valid
	input  wire logic       i_rpl_ready,  // user accepts reply byte
	output scf_resp_t       o_resp,       // reply header and errors
	output logic            o_resp_valid  // one pulse per ended reply
);

	// ==========================================================
	// pin-side inputs pass three flops; change once 2nd and 3rd agree
	logic [2:0] rxv_sync_r;
	logic [7:0] rxd_s1_r, rxd_s2_r, rxd_s3_r;
	logic       rx_stb;
	logic       rxv_seen_r;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rxv_sync_r <= '0;
			rxd_s1_r   <= '0;
			rxd_s2_r   <= '0;
			rxd_s3_r   <= '0;
		end else begin
			rxv_sync_r <= {rxv_sync_r[1:0], i_rx_valid};
			rxd_s1_r   <= i_rx_data;
			rxd_s2_r   <= rxd_s1_r;
			rxd_s3_r   <= rxd_s2_r;
		end
	end

	// strobe taken once per agreed high level of the valid line
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rxv_seen_r <= 1'b0;
		end else if (rxv_sync_r[2] == rxv_sync_r[1]) begin
			rxv_seen_r <= rxv_sync_r[2];
		end
	end
	assign rx_stb = (rxv_sync_r[2] && rxv_sync_r[1]) && !rxv_seen_r;

	// ==========================================================
	// transmit path
	scf_field_t  tx_fld_r;
	logic        tx_busy_r;
	scf_hdr_t    hdr_r;
	logic [15:0] tx_cnt_r;
	logic [15:0] tx_sum_r;
	logic [7:0]  tx_byte;
	logic        tx_byte_ok;
	logic        buf_ready;
	logic        tx_adv;
	logic        wait_rpl_r;

	always_comb begin
		tx_byte    = SCF_START_BYTE;
		tx_byte_ok = tx_busy_r;
		case (tx_fld_r)
			SCF_FLD_START:  tx_byte = SCF_START_BYTE;
			SCF_FLD_ADDR_L: tx_byte = hdr_r.addr[7:0];
			SCF_FLD_ADDR_H: tx_byte = hdr_r.addr[15:8];
			SCF_FLD_CMD_L:  tx_byte = hdr_r.cmd[7:0];
			SCF_FLD_CMD_H:  tx_byte = hdr_r.cmd[15:8];
			SCF_FLD_LEN_L:  tx_byte = hdr_r.len[7:0];
			SCF_FLD_LEN_H:  tx_byte = hdr_r.len[15:8];
			// payload passes in user order, lsb first
			SCF_FLD_DATA: begin
				tx_byte    = i_pl_data;
				tx_byte_ok = tx_busy_r && i_pl_valid;
			end
			SCF_FLD_SUM_L:  tx_byte = tx_sum_r[7:0];
			SCF_FLD_SUM_H:  tx_byte = tx_sum_r[15:8];
			SCF_FLD_CR:     tx_byte = SCF_TERM_CR;
			SCF_FLD_LF:     tx_byte = SCF_TERM_LF;
			default:        tx_byte_ok = 1'b0;
		endcase
	end

	assign tx_adv     = tx_byte_ok && buf_ready;
	assign o_pl_ready = tx_busy_r && (tx_fld_r == SCF_FLD_DATA) && buf_ready;

	scf_skid_buf #(
		.WIDTH (8),
		.DEPTH (BUF_DEPTH)
	) u_tx_buf (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_data    (tx_byte),
		.i_valid   (tx_byte_ok),
		.o_ready   (buf_ready),
		.o_data    (o_tx_data),
		.o_valid   (o_tx_valid),
		.i_ready   (i_tx_ready)
	);

	// a new request only when idle and no reply is pending
	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			o_req_ready <= 1'b0;
		end else begin
			o_req_ready <= !tx_busy_r && !wait_rpl_r && !(i_req_valid && o_req_ready);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			tx_busy_r <= 1'b0;
			tx_fld_r  <= SCF_FLD_START;
			hdr_r     <= '0;
			tx_cnt_r  <= '0;
			tx_sum_r  <= '0;
		end else if (!tx_busy_r) begin
			if (i_req_valid && o_req_ready) begin
				tx_busy_r <= 1'b1;
				tx_fld_r  <= SCF_FLD_START;
				hdr_r     <= i_req_hdr;
				tx_cnt_r  <= i_req_hdr.len;
				tx_sum_r  <= '0;
			end
		end else if (tx_adv) begin
			// sum wraps at 16 bits; start byte excluded
			if (tx_fld_r != SCF_FLD_START && tx_fld_r < SCF_FLD_SUM_L) begin
				tx_sum_r <= tx_sum_r + {8'h00, tx_byte};
			end
			case (tx_fld_r)
				SCF_FLD_LEN_H: begin
					// skip payload when length is zero
					tx_fld_r <= (tx_cnt_r == SCF_ZERO16) ? SCF_FLD_SUM_L : SCF_FLD_DATA;
				end
				SCF_FLD_DATA: begin
					tx_cnt_r <= tx_cnt_r - SCF_ONE16;
					if (tx_cnt_r == SCF_ONE16) begin
						tx_fld_r <= SCF_FLD_SUM_L;
					end
				end
				SCF_FLD_LF: begin
					tx_busy_r <= 1'b0;
					tx_fld_r  <= SCF_FLD_START;
				end
				default: tx_fld_r <= scf_field_t'(tx_fld_r + 4'h1);
			endcase
		end
	end

	// ==========================================================
	// receive parser
	scf_field_t  rx_fld_r;
	logic        rx_act_r;
	logic [15:0] rx_cnt_r;
	logic [15:0] rx_sum_r;
	logic [15:0] rx_chk_r;
	logic        rx_term_bad_r;
	scf_resp_t   rx_hdr_r;
	logic        rpl_push;
	logic [8:0]  rpl_beat;

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			wait_rpl_r <= 1'b0;
		end else if (tx_busy_r && tx_adv && tx_fld_r == SCF_FLD_LF) begin
			wait_rpl_r <= 1'b1;
		end else if (rx_stb && rx_act_r && rx_fld_r == SCF_FLD_LF) begin
			wait_rpl_r <= 1'b0;
		end
	end

	// payload byte pushed to the reply buffer; a full buffer drops it and
	// the user sees a short reply, the link itself cannot be stalled
	// reply data to user
	assign rpl_push = rx_stb && rx_act_r && rx_fld_r == SCF_FLD_DATA;
	assign rpl_beat = {rxd_s3_r, rx_cnt_r == SCF_ONE16};

	scf_skid_buf #(
		.WIDTH (9),
		.DEPTH (BUF_DEPTH)
	) u_rpl_buf (
		.i_clock   (i_clock),
		.i_sys_rst (i_sys_rst),
		.i_data    (rpl_beat),
		.i_valid   (rpl_push),
		.o_ready   (),
		.o_data    ({o_rpl_data, o_rpl_last}),
		.o_valid   (o_rpl_valid),
		.i_ready   (i_rpl_ready)
	);

	always_ff @(posedge i_clock) begin
		if (i_sys_rst) begin
			rx_act_r      <= 1'b0;
			rx_fld_r      <= SCF_FLD_START;
			rx_cnt_r      <= '0;
			rx_sum_r      <= '0;
			rx_chk_r      <= '0;
			rx_term_bad_r <= 1'b0;
			rx_hdr_r      <= '0;
			o_resp        <= '0;
			o_resp_valid  <= 1'b0;
		end else begin
			o_resp_valid <= 1'b0;
			if (rx_stb) begin
				if (!rx_act_r || rx_fld_r == SCF_FLD_START) begin
					if (rxd_s3_r == SCF_START_BYTE) begin
						rx_act_r      <= 1'b1;
						rx_fld_r      <= SCF_FLD_ADDR_L;
						rx_sum_r      <= '0;
						rx_term_bad_r <= 1'b0;
					end
				end else begin
					// running sum wraps at 16 bits
					if (rx_fld_r < SCF_FLD_SUM_L) begin
						rx_sum_r <= rx_sum_r + {8'h00, rxd_s3_r};
					end
					case (rx_fld_r)
						SCF_FLD_ADDR_L: rx_hdr_r.addr[7:0]  <= rxd_s3_r;
						SCF_FLD_ADDR_H: rx_hdr_r.addr[15:8] <= rxd_s3_r;
						SCF_FLD_CMD_L:  rx_hdr_r.cmd[7:0]   <= rxd_s3_r;
						SCF_FLD_CMD_H:  rx_hdr_r.cmd[15:8]  <= rxd_s3_r;
						SCF_FLD_LEN_L: begin
							rx_hdr_r.len[7:0] <= rxd_s3_r;
							rx_cnt_r[7:0]     <= rxd_s3_r;
						end
						SCF_FLD_LEN_H: begin
							rx_hdr_r.len[15:8] <= rxd_s3_r;
							rx_cnt_r[15:8]     <= rxd_s3_r;
						end
						SCF_FLD_SUM_L:  rx_chk_r[7:0]  <= rxd_s3_r;
						SCF_FLD_SUM_H:  rx_chk_r[15:8] <= rxd_s3_r;
						SCF_FLD_DATA:   rx_cnt_r <= rx_cnt_r - SCF_ONE16;
						SCF_FLD_CR: rx_term_bad_r <= (rxd_s3_r != SCF_TERM_CR);
						default: ;
					endcase
					case (rx_fld_r)
						// zero length goes straight to checksum
						SCF_FLD_LEN_H: begin
							rx_fld_r <= ({rxd_s3_r, rx_cnt_r[7:0]} == SCF_ZERO16)
								? SCF_FLD_SUM_L : SCF_FLD_DATA;
						end
						SCF_FLD_DATA: begin
							if (rx_cnt_r == SCF_ONE16) begin
								rx_fld_r <= SCF_FLD_SUM_L;
							end
						end
						SCF_FLD_LF: begin
							rx_act_r         <= 1'b0;
							rx_fld_r         <= SCF_FLD_START;
							o_resp.addr      <= rx_hdr_r.addr;
							o_resp.cmd       <= rx_hdr_r.cmd;
							o_resp.len       <= rx_hdr_r.len;
							o_resp.sum_err   <= (rx_sum_r != rx_chk_r);
							o_resp.term_err  <= rx_term_bad_r || (rxd_s3_r != SCF_TERM_LF);
							o_resp_valid     <= 1'b1;
						end
						default: rx_fld_r <= scf_field_t'(rx_fld_r + 4'h1);
					endcase
				end
			end
		end
	end

endmodule : scf_host_framer
`default_nettype wire

/* File: tb/scf_host_framer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checker
module scf_host_framer_sva
	import scf_pkg::*;
(
	input wire logic	i_clock,	// clk
	input wire logic	i_sys_rst,	// rst
	input wire scf_hdr_t	i_req_hdr,	// hdr
	input wire logic	i_req_valid,	// req
	input wire logic	o_req_ready,	// idle
	input wire logic [7:0]	i_pl_data,	// pl
	input wire logic	i_pl_valid,	// pl
	input wire logic	o_pl_ready,	// pl
	input wire logic [7:0]	o_tx_data,	// link
	input wire logic	o_tx_valid,	// link
	input wire logic	i_tx_ready,	// link
	input wire logic [7:0]	i_rx_data,	// link
	input wire logic	i_rx_valid,	// link
	input wire logic [7:0]	o_rpl_data,	// reply
	input wire logic	o_rpl_last,	// reply
	input wire logic	o_rpl_valid,	// reply
	input wire logic	i_rpl_ready,	// reply
	input wire scf_resp_t	o_resp,	// summary
	input wire logic	o_resp_valid	// summary
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_sys_rst);
	// ==========
	// assertions
	a_start_first: assert property (i_req_valid && o_req_ready |->
		##2 o_tx_valid && o_tx_data == SCF_START_BYTE) else $error("no start byte");
	a_req_busy: assert property (i_req_valid && o_req_ready |=> !o_req_ready [*8])
		else $error("second request taken");
	a_idle_quiet: assert property (o_req_ready |-> !o_tx_valid && !o_pl_ready)
		else $error("idle but sending");
	a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
		else $error("link byte lost");
	a_rpl_hold: assert property (o_rpl_valid && !i_rpl_ready |=> $stable(o_rpl_data))
		else $error("reply byte lost");
	a_resp_pulse: assert property (o_resp_valid |=> !o_resp_valid)
		else $error("summary pulse too long");
	a_resp_update: assert property ($changed(o_resp) |-> ##[0:1] o_resp_valid)
		else $error("summary changed silently");
	a_resp_release: assert property (o_resp_valid |-> ##[0:3] o_req_ready)
		else $error("not idle after reply");
	c_request: cover property (i_req_valid && o_req_ready);
	c_sum_err: cover property (o_resp_valid && o_resp.sum_err);
	c_rpl_last: cover property (o_rpl_valid && o_rpl_last && i_rpl_ready);
endmodule : scf_host_framer_sva
bind scf_host_framer scf_host_framer_sva chk_u (.*);
`default_nettype wire

/* File: tb/scf_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// sensor on the far side
module scf_sensor_model
	import scf_pkg::*;
#(
	parameter logic [15:0] SET_ADDR	= 16'h0011,
	parameter logic [15:0] ACK	= 16'h0000,
	parameter logic [15:0] NACK	= 16'h0001
) (
	input wire logic	i_clock,	// clock
	input wire logic [7:0]	i_tx_data,	// host byte
	input wire logic	i_tx_valid,	// host byte valid
	output var logic	o_tx_ready,	// byte accepted
	output var logic [7:0]	o_rx_data,	// reply byte
	output var logic	o_rx_valid,	// reply strobe
	input wire logic	i_bad,	// spoil reply sum and end byte
	input wire logic	i_slow	// stall host
);
	typedef logic [7:0] scf_bq_t[$];
	logic [15:0]	own_addr_r = SCF_DEF_ADDR;
	logic [7:0]	q[$];
	logic [3:0]	cnt_r = 4'h0;
	function automatic scf_bq_t build_frame(input logic [15:0] a, input logic [15:0] c,
		input logic [7:0] pl[$], input logic bad);
		scf_bq_t f;
		logic [15:0] n, s;
		n = 16'(pl.size());
		f = {SCF_START_BYTE, a[7:0], a[15:8], c[7:0], c[15:8], n[7:0], n[15:8], pl};
		s = 16'h0000;
		for (int k = 1; k < f.size(); k++) s += f[k];
		if (bad) s = ~s;
		// termination; a spoiled frame also breaks its first end byte
		f = {f, s[7:0], s[15:8], bad ? ~SCF_TERM_CR : SCF_TERM_CR, SCF_TERM_LF};
		return f;
	endfunction : build_frame
	always @(negedge i_clock) begin
		cnt_r <= cnt_r + 4'h1;
		o_tx_ready <= !i_slow || cnt_r[1];
	end
	always @(posedge i_clock)
		if (i_tx_valid && o_tx_ready && (q.size() != 0 || i_tx_data == SCF_START_BYTE))
			q.push_back(i_tx_data);
	initial begin
		logic [7:0] p[$], rp[$];
		logic [15:0] a, c, rc;
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		forever begin
			@(posedge i_clock);
			if (q.size() >= 7 && q.size() == 11 + {q[6], q[5]}) begin
				p = q;
				q = {};
				a = {p[2], p[1]};
				c = {p[4], p[3]};
				rp = p[7:p.size()-5];
				if (a == own_addr_r && build_frame(a, c, rp, 1'b0) == p) begin
					if (c == SET_ADDR && rp.size() == 2) own_addr_r = {rp[1], rp[0]};
					rc = (rp.size() == 0) ? c : ACK;
					if (c == SET_ADDR && rp.size() != 2) rc = NACK;
					if (rp.size() != 0) rp = {};
					else
						for (int k = 0; k < 4; k++) rp.push_back(c[7:0] + 8'(k));
					p = build_frame(a, rc, rp, i_bad);
					foreach (p[k]) begin
						@(negedge i_clock);
						o_rx_data = p[k];
						o_rx_valid = 1'b1;
						repeat (4) @(negedge i_clock);
						o_rx_valid = 1'b0;
						@(negedge i_clock);
						// line no longer held, so show junk
						o_rx_data = ~p[k];
						repeat (3) @(negedge i_clock);
					end
				end
			end
		end
	end
endmodule : scf_sensor_model
`default_nettype wire

/* File: tb/sensor_command_packet_framer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_command_packet_framer_tb_top
	import scf_pkg::*;
;
	localparam logic [15:0] SET_ADDR	= 16'h0011;
	localparam logic [15:0] ACK	= 16'h0000;
	localparam logic [15:0] NACK	= 16'h0001;
	logic	i_clock = 1'b0, i_sys_rst = 1'b1, i_req_valid = 1'b0, i_pl_valid = 1'b0;
	logic	i_rpl_ready = 1'b0, bad = 1'b0, slow = 1'b0, i_tx_ready, i_rx_valid;
	logic	o_req_ready, o_pl_ready, o_tx_valid, o_rpl_last, o_rpl_valid, o_resp_valid;
	logic [7:0]	i_pl_data = 8'h00, o_tx_data, i_rx_data, o_rpl_data;
	scf_hdr_t	i_req_hdr = '0;
	scf_resp_t	o_resp;
	logic [31:0]	seed_r = 32'h0000002d;
	logic [7:0]	exp_tx[$], got_rpl[$], txpl[$];
	int	exp_n, miscompares = 0, total_checks = 0;
	scf_host_framer dut_u (.*);
	scf_sensor_model #(.SET_ADDR(SET_ADDR), .ACK(ACK), .NACK(NACK)) sens_u (.i_clock(i_clock),
		.i_tx_data(o_tx_data), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready),
		.o_rx_data(i_rx_data), .o_rx_valid(i_rx_valid), .i_bad(bad), .i_slow(slow));
	initial forever #12.5 i_clock = ~i_clock;
	function logic [31:0] rnd();
		seed_r ^= seed_r << 13;
		seed_r ^= seed_r >> 17;
		seed_r ^= seed_r << 5;
		return seed_r;
	endfunction : rnd
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task end_sim();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// ==========
	// monitors
	always @(posedge i_clock) begin
		if (o_tx_valid && i_tx_ready) chk("tx byte", exp_tx.pop_front(), o_tx_data);
		if (o_rpl_valid && i_rpl_ready) begin
			chk("reply last", 64'(got_rpl.size() == exp_n - 1), 64'(o_rpl_last));
			got_rpl.push_back(o_rpl_data);
		end
	end
	always @(negedge i_clock) i_rpl_ready = (rnd() % 4) != 0;
	// ==========
	// one request and its reply
	task automatic txn(input logic [15:0] a, input logic [15:0] c, input int n,
		input logic [15:0] rc, input int rn, input logic err);
		logic [7:0] rp[$];
		txpl = {};
		for (int k = 0; k < n; k++) txpl.push_back(8'(rnd()));
		for (int k = 0; k < rn; k++) rp.push_back(c[7:0] + 8'(k));
		exp_tx = sens_u.build_frame(a, c, txpl, 1'b0);
		exp_n = rn;
		got_rpl = {};
		@(negedge i_clock);
		i_req_hdr = '{a, c, 16'(n)};
		i_req_valid = 1'b1;
		do @(posedge i_clock); while (!o_req_ready);
		@(negedge i_clock);
		i_req_valid = 1'b0;
		foreach (txpl[k]) begin
			i_pl_data = txpl[k];
			i_pl_valid = 1'b1;
			do @(posedge i_clock); while (!o_pl_ready);
			@(negedge i_clock);
		end
		i_pl_valid = 1'b0;
		do @(posedge i_clock); while (!o_resp_valid);
		chk("summary", 64'(scf_resp_t'{a, rc, 16'(rn), err, err}), 64'(o_resp));
		repeat (12) @(posedge i_clock);
		chk("reply count", 64'(rn), 64'(got_rpl.size()));
		foreach (rp[k]) chk("reply byte", 64'(rp[k]), 64'(got_rpl[k]));
		chk("tx left", 64'h0, 64'(exp_tx.size()));
		$display("test done cmd %h len %0d", c, n);
	endtask : txn
	initial begin
		logic [15:0] na;
		repeat (20) @(negedge i_clock);
		i_sys_rst = 1'b0;
		slow = 1'b1;
		txn(SCF_DEF_ADDR, 16'h0005, 0, 16'h0005, 4, 1'b0);
		txn(SCF_DEF_ADDR, SET_ADDR, 3, NACK, 0, 1'b0);
		txn(SCF_DEF_ADDR, SET_ADDR, 2, ACK, 0, 1'b0);
		na = {txpl[1], txpl[0]};
		slow = 1'b0;
		txn(na, 16'h003a, 0, 16'h003a, 4, 1'b0);
		bad = 1'b1;
		txn(na, 16'h0022, 0, 16'h0022, 4, 1'b1);
		bad = 1'b0;
		for (int j = 1; j < 7; j++) txn(na, 16'h0100 | 16'(rnd()), j, ACK, 0, 1'b0);
		end_sim();
	end
	// eleven short exchanges need a few thousand cycles; 20000 is ample
	initial begin
		#500000;
		miscompares++;
		end_sim();
	end
endmodule : sensor_command_packet_framer_tb_top
`default_nettype wire
